/* verilog/iic_consts.vh */
// constants for the two-wire bus control and status block
`ifndef IIC_CONSTS_VH
`define IIC_CONSTS_VH
// register offsets on the plain register port
`define IIC_OFS_CONTROL 3'h0
`define IIC_OFS_STATUS 3'h1
`define IIC_OFS_DATA 3'h2
`define IIC_OFS_MODE 3'h3
`define IIC_OFS_STC 3'h4
// bus_control fields
`define IIC_CR_ENABLE 7
`define IIC_CR_IRQEN 6
`define IIC_CR_MASTER 5
`define IIC_CR_TRANSMIT 4
`define IIC_CR_ACKMODE 3
`define IIC_CR_CLK_HI 2
`define IIC_CR_CLK_LO 0
// bus_status fields
`define IIC_SR_BUSY 7
`define IIC_SR_IRQ 6
`define IIC_SR_COND 5
`define IIC_SR_ARB 3
`define IIC_SR_ADDR 2
`define IIC_SR_GCALL 1
`define IIC_SR_ACK 0
// mode / own address fields
`define IIC_MR_LSB 7
`define IIC_MR_WAIT 6
`define IIC_MR_BC_HI 2
`define IIC_MR_BC_LO 0
`define IIC_MR_RSV 3'h7
// serial_timer_control fields
`define IIC_STC_EXTRA 7
`define IIC_STC_RANGE0 5
// reset values
`define IIC_RST_CONTROL 8'h00
`define IIC_RST_STATUS_HI 2'h3
`define IIC_RST_STC 8'h00
`define IIC_RST_OWN 8'h00
// general call address byte
`define IIC_GCALL_ADDR 8'h00
// scl divisors, peripheral clock cycles per scl period
`define IIC_DIV_00 9'h01c
`define IIC_DIV_01 9'h028
`define IIC_DIV_02 9'h030
`define IIC_DIV_03 9'h040
`define IIC_DIV_04 9'h050
`define IIC_DIV_05 9'h064
`define IIC_DIV_06 9'h070
`define IIC_DIV_07 9'h080
`define IIC_DIV_10 9'h038
`define IIC_DIV_11 9'h050
`define IIC_DIV_12 9'h060
`define IIC_DIV_13 9'h080
`define IIC_DIV_14 9'h0a0
`define IIC_DIV_15 9'h0c8
`define IIC_DIV_16 9'h0e0
`define IIC_DIV_17 9'h100
`endif

/* verilog/iic_clk_div.v */
// half-period tick generator for master scl
`include "iic_consts.vh"
module iic_clk_div (
	input wire clk,
	input wire rst,
	input wire run,
	input wire [3:0] sel,
	output wire tick
);
	reg [8:0] div;
	reg [7:0] cnt_reg;
	wire [7:0] half;

	// divisor table, range bit on top
	always @*
	begin
		case (sel)
			4'h0: div = `IIC_DIV_00;
			4'h1: div = `IIC_DIV_01;
			4'h2: div = `IIC_DIV_02;
			4'h3: div = `IIC_DIV_03;
			4'h4: div = `IIC_DIV_04;
			4'h5: div = `IIC_DIV_05;
			4'h6: div = `IIC_DIV_06;
			4'h7: div = `IIC_DIV_07;
			4'h8: div = `IIC_DIV_10;
			4'h9: div = `IIC_DIV_11;
			4'ha: div = `IIC_DIV_12;
			4'hb: div = `IIC_DIV_13;
			4'hc: div = `IIC_DIV_14;
			4'hd: div = `IIC_DIV_15;
			4'he: div = `IIC_DIV_16;
			default: div = `IIC_DIV_17;
		endcase
	end

	assign half = div[8:1];
	assign tick = run & (cnt_reg == half - 8'h01);

	// free count, restarted when idle or at each tick
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_reg <= 8'h00;
		else if (~run | tick)
			cnt_reg <= 8'h00;
		else
			cnt_reg <= cnt_reg + 8'h01;
	end
endmodule

/* verilog/iic_flag.v */
// sticky status flag, cleared by read-as-one then write-zero
module iic_flag (
	input wire clk,
	input wire rst,
	input wire set,
	input wire auto_clr,
	input wire read_seen,
	input wire write_zero,
	output reg flag
);
	reg armed_reg;
	wire sw_clr;

	assign sw_clr = write_zero & armed_reg;

	// set wins over any clear in the same cycle
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			flag <= 1'b0;
			armed_reg <= 1'b0;
		end
		else
		begin
			flag <= set | (flag & ~(auto_clr | sw_clr));
			if (set | auto_clr | sw_clr)
				armed_reg <= 1'b0;
			else if (read_seen & flag)
				armed_reg <= 1'b1;
		end
	end
endmodule

/* verilog/iic_ctrl.v */
// two-wire bus interface: mode, status, framing and master clock
// Function
// - master and transmit select give slave/master receive/transmit; reset is slave receive
// - arbitration loss clears master and transmit select
// - addressed slave takes transmit direction from first byte's direction bit
// - frame is bit count plus acknowledge, or bit count only in serial mode
// - master scl divides clock by table chosen by range and divider select
// - busy set on start condition, cleared on stop condition
// - busy one with strobe zero requests start; both zero requests stop
// - busy writes ignored in slave mode
// - irq flag at transfer end, address match, arbitration loss
// - addressed slave irq on match and each end until start or stop
// - flags cleared by read as one then write zero; irq flag by nothing else
// - data write when transmitting or data read when receiving clears arbitration, address and general call flags
// - arbitration lost on sda mismatch at rise or scl high at fall
// - address match on own address or general call in first byte
// - general call flag on first byte equal to general call address
// - acknowledge captured when transmitting, driven when receiving; read by direction
// - strobe bit and reserved bit read one, writes not stored
// - extra buffer select gives port bits bus drive buffers
// - status resets to 30 hex, serial timer control to 00
// - cpu interrupt passes only with irq enable set
// - enable drives the pins; disabled releases both and stops
// - bit count cleared at reset, start and end of each frame
`include "iic_consts.vh"
module iic_ctrl (
	input wire clk,
	input wire rst,
	input wire [2:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe_n,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe_n,
	output wire port_bus_drive,
	output wire irq
);
	localparam ST_IDLE = 2'h0;
	localparam ST_XFER = 2'h1;
	localparam ST_HOLD = 2'h2;
	localparam G_NONE = 3'h0;
	localparam G_START_REL = 3'h1;
	localparam G_START_SDA = 3'h2;
	localparam G_START_SCL = 3'h3;
	localparam G_STOP_SDA = 3'h4;
	localparam G_STOP_SCL = 3'h5;
	localparam G_STOP_REL = 3'h6;

	reg enable_reg;
	reg irq_enable_reg;
	reg master_reg;
	reg transmit_reg;
	reg ack_mode_reg;
	reg [2:0] cks_reg;
	reg [7:0] stc_reg;
	reg lsb_first_reg;
	reg wait_reg;
	reg [2:0] bit_count_reg;
	reg [6:0] own_addr_reg;
	reg format_reg;
	reg ack_sw_reg;
	reg ack_bus_reg;
	reg busy_reg;
	reg [7:0] data_shift_reg;
	reg [1:0] st_reg;
	reg [2:0] gen_reg;
	reg [3:0] bit_pos_reg;
	reg first_byte_reg;
	reg addressed_reg;
	reg scl_low_reg;
	reg sda_low_reg;
	reg scl_prev_reg;
	reg sda_prev_reg;

	wire ctrl_wr;
	wire status_wr;
	wire status_rd;
	wire data_wr;
	wire data_rd;
	wire mode_wr;
	wire stc_wr;
	wire start_det;
	wire stop_det;
	wire scl_rise;
	wire scl_fall;
	wire tick;
	wire go;
	wire [3:0] data_bits;
	wire [3:0] frame_len;
	wire [3:0] pos_inc;
	wire in_data;
	wire frame_end;
	wire addr_check;
	wire [7:0] byte_in;
	wire match_gc;
	wire match_own;
	wire addr_match;
	wire arb_lost;
	wire cond_wr;
	wire [7:0] tx_byte;
	wire irq_f;
	wire al_f;
	wire aas_f;
	wire adz_f;
	wire irq_set;

	// register port decode
	assign ctrl_wr = wr & (addr == `IIC_OFS_CONTROL);
	assign status_wr = wr & (addr == `IIC_OFS_STATUS);
	assign status_rd = rd & (addr == `IIC_OFS_STATUS);
	assign data_wr = wr & (addr == `IIC_OFS_DATA);
	assign data_rd = rd & (addr == `IIC_OFS_DATA);
	assign mode_wr = wr & (addr == `IIC_OFS_MODE);
	assign stc_wr = wr & (addr == `IIC_OFS_STC);

	// bus condition and edge detection on the sampled lines
	assign start_det = scl_prev_reg & scl_in & sda_prev_reg & ~sda_in;
	assign stop_det = scl_prev_reg & scl_in & ~sda_prev_reg & sda_in;
	assign scl_rise = ~scl_prev_reg & scl_in;
	assign scl_fall = scl_prev_reg & ~scl_in;

	// frame geometry; first byte after a start is always eight bits
	assign data_bits = first_byte_reg ? 4'h8 :
		((bit_count_reg == 3'h0) ? 4'h8 : {1'b0, bit_count_reg});
	assign frame_len = data_bits + (ack_mode_reg ? 4'h0 : 4'h1);
	assign pos_inc = bit_pos_reg + 4'h1;
	assign in_data = bit_pos_reg < data_bits;
	assign frame_end = (st_reg == ST_XFER) & scl_rise & (pos_inc == frame_len);

	// data register access that starts the next frame
	assign go = (transmit_reg & data_wr) | (~transmit_reg & data_rd);
	assign tx_byte = data_wr ? wdata : data_shift_reg;

	// slave address recognition on the eighth bit of the first byte
	assign byte_in = {data_shift_reg[6:0], sda_in};
	assign addr_check = (st_reg == ST_XFER) & scl_rise & first_byte_reg &
		(bit_pos_reg == 4'h7) & ~master_reg & ~format_reg & ~transmit_reg;
	assign match_gc = byte_in == `IIC_GCALL_ADDR;
	assign match_own = byte_in[7:1] == own_addr_reg;
	assign addr_match = addr_check & (match_own | match_gc);

	// arbitration watch while this end transmits as master
	assign arb_lost = enable_reg & master_reg & transmit_reg & (st_reg == ST_XFER) &
		((scl_rise & in_data & ~sda_low_reg & ~sda_in) |
		(scl_fall & ~scl_low_reg & (gen_reg == G_NONE)));

	// condition request; slave mode drops it entirely
	assign cond_wr = status_wr & enable_reg & master_reg & ~wdata[`IIC_SR_COND];

	// irq sources, slave only while addressed or non-addressed format
	assign irq_set = (frame_end & (master_reg | format_reg | addressed_reg)) |
		addr_match | arb_lost;

	// value to drive for bit position pos of the frame
	function drive_low_for;
		input [3:0] pos;
		begin
			if (pos < data_bits)
				drive_low_for = transmit_reg & ~(lsb_first_reg ? tx_byte[pos[2:0]] :
					tx_byte[3'h7 - pos[2:0]]);
			else if (ack_mode_reg)
				drive_low_for = 1'b0;
			else if (first_byte_reg & addressed_reg)
				drive_low_for = 1'b1;
			else
				drive_low_for = ~transmit_reg & ~ack_sw_reg;
		end
	endfunction

	iic_clk_div u_div (
		.clk(clk),
		.rst(rst),
		.run(enable_reg & master_reg),
		.sel({stc_reg[`IIC_STC_RANGE0], cks_reg}),
		.tick(tick)
	);

	iic_flag u_irq (
		.clk(clk),
		.rst(rst),
		.set(irq_set),
		.auto_clr(1'b0),
		.read_seen(status_rd),
		.write_zero(status_wr & ~wdata[`IIC_SR_IRQ]),
		.flag(irq_f)
	);

	iic_flag u_al (
		.clk(clk),
		.rst(rst),
		.set(arb_lost),
		.auto_clr(go),
		.read_seen(status_rd),
		.write_zero(status_wr & ~wdata[`IIC_SR_ARB]),
		.flag(al_f)
	);

	iic_flag u_aas (
		.clk(clk),
		.rst(rst),
		.set(addr_match),
		.auto_clr(go),
		.read_seen(status_rd),
		.write_zero(status_wr & ~wdata[`IIC_SR_ADDR]),
		.flag(aas_f)
	);

	iic_flag u_adz (
		.clk(clk),
		.rst(rst),
		.set(addr_check & match_gc),
		.auto_clr(go),
		.read_seen(status_rd),
		.write_zero(status_wr & ~wdata[`IIC_SR_GCALL]),
		.flag(adz_f)
	);

	// bus_control; hardware updates take priority over software
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			{enable_reg, irq_enable_reg, master_reg, transmit_reg, ack_mode_reg,
				cks_reg} <= `IIC_RST_CONTROL;
		end
		else
		begin
			if (ctrl_wr)
			begin
				enable_reg <= wdata[`IIC_CR_ENABLE];
				irq_enable_reg <= wdata[`IIC_CR_IRQEN];
				ack_mode_reg <= wdata[`IIC_CR_ACKMODE];
				cks_reg <= wdata[`IIC_CR_CLK_HI:`IIC_CR_CLK_LO];
			end
			if (arb_lost)
			begin
				master_reg <= 1'b0;
				transmit_reg <= 1'b0;
			end
			else if (addr_match & ~match_gc)
				transmit_reg <= byte_in[0];
			else if (ctrl_wr)
			begin
				master_reg <= wdata[`IIC_CR_MASTER];
				transmit_reg <= wdata[`IIC_CR_TRANSMIT];
			end
		end
	end

	// mode, own address, serial_timer_control, acknowledge and busy
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stc_reg <= `IIC_RST_STC;
			lsb_first_reg <= 1'b0;
			wait_reg <= 1'b0;
			bit_count_reg <= 3'h0;
			{own_addr_reg, format_reg} <= `IIC_RST_OWN;
			ack_sw_reg <= 1'b0;
			ack_bus_reg <= 1'b0;
			busy_reg <= 1'b0;
		end
		else
		begin
			if (stc_wr)
				stc_reg <= wdata;
			if (mode_wr & ~enable_reg)
				{own_addr_reg, format_reg} <= wdata;
			if (mode_wr & enable_reg)
			begin
				lsb_first_reg <= wdata[`IIC_MR_LSB];
				wait_reg <= wdata[`IIC_MR_WAIT];
			end
			if (start_det | frame_end)
				bit_count_reg <= 3'h0;
			else if (mode_wr & enable_reg)
				bit_count_reg <= wdata[`IIC_MR_BC_HI:`IIC_MR_BC_LO];
			if (status_wr)
				ack_sw_reg <= wdata[`IIC_SR_ACK];
			if ((st_reg == ST_XFER) & scl_rise & ~in_data & transmit_reg)
				ack_bus_reg <= sda_in;
			if (start_det)
				busy_reg <= 1'b1;
			else if (stop_det)
				busy_reg <= 1'b0;
		end
	end

	// line sampling for edge and condition detection
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end
		else
		begin
			scl_prev_reg <= scl_in;
			sda_prev_reg <= sda_in;
		end
	end

	// frame engine, master clock and condition generator
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_reg <= ST_IDLE;
			gen_reg <= G_NONE;
			bit_pos_reg <= 4'h0;
			first_byte_reg <= 1'b0;
			addressed_reg <= 1'b0;
			scl_low_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			data_shift_reg <= 8'h00;
		end
		else if (~enable_reg | arb_lost)
		begin
			st_reg <= ST_IDLE;
			gen_reg <= G_NONE;
			addressed_reg <= 1'b0;
			scl_low_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			if (data_wr)
				data_shift_reg <= wdata;
		end
		else
		begin
			if (data_wr)
				data_shift_reg <= wdata;
			if (start_det)
			begin
				st_reg <= master_reg ? ST_HOLD : ST_XFER;
				bit_pos_reg <= 4'h0;
				first_byte_reg <= 1'b1;
				addressed_reg <= 1'b0;
			end
			else if (stop_det)
			begin
				st_reg <= ST_IDLE;
				first_byte_reg <= 1'b0;
				addressed_reg <= 1'b0;
				sda_low_reg <= 1'b0;
			end
			else
			begin
				case (st_reg)
					ST_HOLD:
					begin
						// slave stretches scl until software services data
						if (scl_fall & ~master_reg)
							scl_low_reg <= 1'b1;
						if (go)
						begin
							st_reg <= ST_XFER;
							bit_pos_reg <= 4'h0;
							sda_low_reg <= drive_low_for(4'h0);
							if (~master_reg)
								scl_low_reg <= 1'b0;
						end
					end
					ST_XFER:
					begin
						// slave follows external scl edges only
						if (scl_rise)
						begin
							bit_pos_reg <= pos_inc;
							if (in_data & ~transmit_reg)
								data_shift_reg <= lsb_first_reg ?
									{sda_in, data_shift_reg[7:1]} : byte_in;
							if (addr_match)
								addressed_reg <= 1'b1;
							else if (addr_check)
								st_reg <= ST_IDLE;
							if (frame_end)
							begin
								st_reg <= ST_HOLD;
								first_byte_reg <= 1'b0;
								bit_pos_reg <= 4'h0;
							end
						end
						if (scl_fall)
							sda_low_reg <= drive_low_for(bit_pos_reg);
					end
					default:
					begin
						sda_low_reg <= 1'b0;
					end
				endcase
				// master scl: release in transfer, pull low after high
				if (master_reg & (gen_reg == G_NONE) & (st_reg != ST_IDLE) & tick)
				begin
					if (scl_low_reg)
						scl_low_reg <= st_reg != ST_XFER;
					else if (scl_in)
						scl_low_reg <= 1'b1;
				end
			end
			// start and stop sequencing on the divider ticks
			if (cond_wr)
				gen_reg <= wdata[`IIC_SR_BUSY] ? G_START_REL : G_STOP_SDA;
			else if (tick)
			begin
				case (gen_reg)
					G_START_REL:
					begin
						sda_low_reg <= 1'b0;
						scl_low_reg <= 1'b0;
						gen_reg <= G_START_SDA;
					end
					G_START_SDA:
					begin
						if (scl_in & sda_in)
						begin
							sda_low_reg <= 1'b1;
							gen_reg <= G_START_SCL;
						end
					end
					G_START_SCL:
					begin
						scl_low_reg <= 1'b1;
						gen_reg <= G_NONE;
					end
					G_STOP_SDA:
					begin
						scl_low_reg <= 1'b1;
						sda_low_reg <= 1'b1;
						gen_reg <= G_STOP_SCL;
					end
					G_STOP_SCL:
					begin
						scl_low_reg <= 1'b0;
						gen_reg <= G_STOP_REL;
					end
					G_STOP_REL:
					begin
						if (scl_in)
						begin
							sda_low_reg <= 1'b0;
							gen_reg <= G_NONE;
						end
					end
					default:
					begin
						gen_reg <= G_NONE;
					end
				endcase
			end
		end
	end

	// read data, valid only in the cycle after the read strobe
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata <= 8'h00;
		else if (rd)
		begin
			case (addr)
				`IIC_OFS_CONTROL: rdata <= {enable_reg, irq_enable_reg, master_reg,
					transmit_reg, ack_mode_reg, cks_reg};
				`IIC_OFS_STATUS: rdata <= {busy_reg, irq_f, `IIC_RST_STATUS_HI, al_f, aas_f,
					adz_f, transmit_reg ? ack_bus_reg : ack_sw_reg};
				`IIC_OFS_DATA: rdata <= data_shift_reg;
				`IIC_OFS_MODE: rdata <= enable_reg ?
					{lsb_first_reg, wait_reg, `IIC_MR_RSV, bit_count_reg} :
					{own_addr_reg, format_reg};
				`IIC_OFS_STC: rdata <= stc_reg;
				default: rdata <= 8'h00;
			endcase
		end
		else
			rdata <= 8'h00;
	end

	// open-drain pins: only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_n = ~(enable_reg & scl_low_reg);
	assign sda_oe_n = ~(enable_reg & sda_low_reg);
	assign port_bus_drive = stc_reg[`IIC_STC_EXTRA];
	assign irq = irq_f & irq_enable_reg;
endmodule

/* sim/iic_monitor.sv */
// port checker for the bus control block
module iic_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe_n,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic port_bus_drive,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ctl_q;
	// shadow of the last control write
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			ctl_q <= 8'h00;
		else if (wr && addr == 3'h0)
			ctl_q <= wdata;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// control write, one idle cycle, then control read
	sequence s_ctl_wr;
		wr && addr == 3'h0;
	endsequence
	sequence s_ctl_rd;
		rd && addr == 3'h0;
	endsequence
	// start request in enabled master mode
	sequence s_start_req;
		wr && addr == 3'h1 && wdata[7:5] == 3'h4 && ctl_q[7] && ctl_q[5];
	endsequence
	ctl_back_a: assert property (s_ctl_wr ##2 s_ctl_rd |=> rdata == $past(wdata, 3))
		else $error("control readback differs from write");
	start_gen_a: assert property (s_start_req |-> ##[1:400] (!sda_oe_n && scl_in))
		else $error("no start condition after request");
	slave_nogen_a: assert property (wr && addr == 3'h1 && ctl_q[7] && !ctl_q[5]
		&& scl_in && sda_in |=> sda_oe_n [*8])
		else $error("slave drove sda after busy write");
	irq_gate_a: assert property (wr && addr == 3'h0 && !wdata[6] |=> !irq)
		else $error("irq output with irq enable clear");
	irq_cause_a: assert property ($rose(irq) |-> ctl_q[6])
		else $error("irq rose without irq enable");
	pins_off_a: assert property (wr && addr == 3'h0 && !wdata[7] |=> scl_oe_n && sda_oe_n)
		else $error("pins driven while disabled");
	stat_fixed_a: assert property (rd && addr == 3'h1 |=> rdata[5:4] == 2'h3)
		else $error("fixed status bits not one");
	xbuf_a: assert property (wr && addr == 3'h4 |=> port_bus_drive == $past(wdata[7]))
		else $error("extra buffer select not followed");
endmodule
bind iic_ctrl iic_monitor u_mon (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_in), .scl_out(scl_out),
	.scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
	.port_bus_drive(port_bus_drive), .irq(irq));

/* sim/iic_bus_model.sv */
// bus peer: acknowledging slave or rival master pulling sda low
module iic_bus_model (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	input wire logic ack_on,
	input wire logic arb_on,
	output logic pull
);
	timeunit 1ns;
	timeprecision 1ns;
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	logic act = 1'b0;
	logic p_ack = 1'b0;
	logic p_arb = 1'b0;
	logic [3:0] cnt = 4'h0;
	assign pull = p_ack | p_arb;
	// frame tracking from start, stop and scl edges
	always @(posedge clk)
	begin
		scl_q <= scl;
		sda_q <= sda;
		if (scl && scl_q && sda_q && !sda)
		begin
			act <= 1'b1;
			cnt <= 4'h0;
		end
		else if (scl && scl_q && !sda_q && sda)
			act <= 1'b0;
		else if (scl && !scl_q)
			cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
		else if (!scl && scl_q)
		begin
			p_ack <= act && ack_on && cnt == 4'h8;
			p_arb <= act && arb_on;
		end
		if (!arb_on)
			p_arb <= 1'b0;
	end
endmodule

/* sim/iic_ctrl_tb.sv */
// self-checking bench for the bus control block
module iic_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic ack_on = 1'b1;
	logic arb_on = 1'b0;
	wire [7:0] rdata;
	wire scl_out, sda_out, scl_oe_n, sda_oe_n, port_bus_drive, irq, pull;
	// open-drain wires with pull-ups
	wire scl_in = scl_oe_n;
	wire sda_in = sda_oe_n & ~pull;
	int n_mismatch = 0;
	int tests_run = 0;
	int i;
	logic [8:0] dv [16] = '{9'h01c, 9'h028, 9'h030, 9'h040, 9'h050, 9'h064, 9'h070, 9'h080,
		9'h038, 9'h050, 9'h060, 9'h080, 9'h0a0, 9'h0c8, 9'h0e0, 9'h100};
	iic_ctrl u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.port_bus_drive(port_bus_drive), .irq(irq));
	iic_bus_model u_peer (.clk(clk), .scl(scl_in), .sda(sda_in), .ack_on(ack_on),
		.arb_on(arb_on), .pull(pull));
	// 20 MHz clock
	initial
	begin
		forever #25 clk = ~clk;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// poll busy until it reads b, then, if b is one, wait for scl low
	task automatic wait_busy(input logic b);
		logic [7:0] st;
		int n;
		for (n = 0; n < 300; n++)
		begin
			rd_reg(3'h1, st);
			if (st[7] === b)
				break;
		end
		chk({8'h00, st[7]}, {8'h00, b});
		for (n = 0; n < 300 && b && scl_in; n++)
			@(posedge clk);
	endtask
	task automatic t_reset;
		logic [7:0] d;
		chk({7'h00, scl_out, sda_out}, 9'h000);
		chk({7'h00, scl_oe_n, sda_oe_n}, 9'h003);
		rd_reg(3'h1, d);
		chk({1'b0, d}, 9'h030);
		rd_reg(3'h4, d);
		chk({1'b0, d}, 9'h000);
		rd_reg(3'h0, d);
		chk({1'b0, d}, 9'h000);
		rd_reg(3'h3, d);
		chk({1'b0, d}, 9'h000);
		rd_reg(3'h5, d);
		chk({1'b0, d}, 9'h000);
	endtask
	task automatic t_regs;
		logic [7:0] d;
		wr_reg(3'h0, 8'h80);
		rd_reg(3'h3, d);
		chk({1'b0, d}, 9'h038);
		// bit count stored now, must be gone once a start is seen
		wr_reg(3'h3, 8'h05);
		rd_reg(3'h3, d);
		chk({1'b0, d}, 9'h03d);
		// software acknowledge level reads back while receiving
		wr_reg(3'h1, 8'hff);
		rd_reg(3'h1, d);
		chk({1'b0, d}, 9'h031);
		wr_reg(3'h0, 8'h30);
		rd_reg(3'h0, d);
		chk({1'b0, d}, 9'h030);
		wr_reg(3'h4, 8'h80);
		chk({8'h00, port_bus_drive}, 9'h001);
		wr_reg(3'h4, 8'h00);
		chk({8'h00, port_bus_drive}, 9'h000);
	endtask
	// one master transmit frame, measuring scl period and pulse count
	task automatic t_xfer(input logic rg, input logic [2:0] cks, input logic am);
		logic [7:0] st;
		int c, r, t0, per;
		logic p;
		wr_reg(3'h4, {2'b00, rg, 5'h00});
		wr_reg(3'h0, {4'hf, am, cks});
		wr_reg(3'h1, 8'h80);
		wait_busy(1'b1);
		rd_reg(3'h3, st);
		chk({1'b0, st}, 9'h038);
		wr_reg(3'h2, 8'h5a);
		r = 0;
		per = 0;
		t0 = 0;
		p = scl_in;
		for (c = 0; c < 4000 && irq !== 1'b1; c++)
		begin
			@(posedge clk);
			#1;
			if (scl_in && !p)
			begin
				r++;
				if (r == 2)
					t0 = c;
				if (r == 3)
					per = c - t0;
			end
			p = scl_in;
		end
		chk(9'(per), dv[{rg, cks}]);
		chk(9'(r), am ? 9'h008 : 9'h009);
		rd_reg(3'h1, st);
		chk({8'h00, st[6]}, 9'h001);
		if (!am)
			chk({8'h00, st[0]}, 9'h000);
		wr_reg(3'h1, 8'h00);
		wait_busy(1'b0);
		chk({8'h00, irq}, 9'h000);
	endtask
	// rival master wins the bus on the first data bit
	task automatic t_arb;
		logic [7:0] st;
		int c;
		arb_on <= 1'b1;
		wr_reg(3'h0, 8'hf0);
		wr_reg(3'h1, 8'h80);
		wait_busy(1'b1);
		wr_reg(3'h2, 8'hff);
		for (c = 0; c < 1000 && irq !== 1'b1; c++)
			@(posedge clk);
		chk({8'h00, irq}, 9'h001);
		wr_reg(3'h1, 8'h00);
		rd_reg(3'h1, st);
		chk({1'b0, st & 8'h48}, 9'h048);
		rd_reg(3'h0, st);
		chk({7'h00, st[5:4]}, 9'h000);
		wr_reg(3'h0, 8'h80);
		chk({8'h00, irq}, 9'h000);
		wr_reg(3'h0, 8'hc0);
		chk({8'h00, irq}, 9'h001);
		rd_reg(3'h2, st);
		rd_reg(3'h1, st);
		chk({1'b0, st & 8'h48}, 9'h040);
		wr_reg(3'h1, 8'h00);
		rd_reg(3'h1, st);
		chk({1'b0, st & 8'h48}, 9'h000);
		arb_on <= 1'b0;
		wait_busy(1'b0);
	endtask
	// hang guard, about three times the expected run length
	initial
	begin
		#3000000;
		n_mismatch++;
		summarize();
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		for (i = 0; i < 16; i++)
			t_xfer(i[3], i[2:0], 1'b0);
		ack_on <= 1'b0;
		t_xfer(1'b0, 3'h1, 1'b1);
		ack_on <= 1'b1;
		t_arb();
		summarize();
	end
endmodule
